// ### core/upc_pin_ctrl.sv
// Behaviour
// - After reset the ULPI clock pin is an input, absent a reference clock.
// - A detected reference clock makes the ULPI clock pin an output while the chip is selected.
// - Chip reset clears all logic but the always-on charger logic.
// - During reset the PLL is off; normal operation resumes on release.
// - Start-of-frame output stays low unless its enable bit is set.
// - When enabled, the start-of-frame output toggles on each SOF packet.
// - Active-low chip select high powers down and tri-states the ULPI bus.
// - Charger-detect enable starts detection only in dead-battery mode.
// - VBUS fault input is used only when the use-outside-flag bit is set.
// - Invert bit sets the polarity of the VBUS fault input.
// - Bypass passes the fault input; otherwise VBUS valid qualifies it.
// - Charger output is active low or high following the polarity pin.
// - Active-high chip select low powers down and tri-states the ULPI bus.
`timescale 1ns/10ps
`default_nettype none

module upc_pin_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic aon_rst_n,
    input wire logic reference_clock_in,
    input wire logic ref_freq_sel,
    input wire logic chip_sel,
    input wire logic chip_sel_low,
    input wire logic ulpi_clk_i,
    output logic ulpi_clk_o,
    output logic ulpi_clk_oe,
    output logic ulpi_clk_from_pin,
    output logic pll_enable,
    output logic pll_ref_26m,
    output logic chip_active,
    output logic ulpi_bus_tristate,
    input wire logic sof_out_en,
    input wire logic hs_sof_rx,
    output logic sof_out,
    input wire logic dead_battery_mode,
    input wire logic charger_detect_enable_low,
    output logic charger_detect_start,
    input wire logic charger_found,
    input wire logic charger_out_polarity,
    output logic charger_detected_o,
    output logic charger_detected_oe,
    input wire logic vbus_fault_in,
    input wire logic use_outside_vbus_flag,
    input wire logic vbus_flag_invert,
    input wire logic vbus_flag_bypass,
    input wire logic vbus_valid_cmp,
    output logic outside_vbus_valid
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic ref_s;
    logic freq_s;
    logic cs_s;
    logic csn_s;
    logic fault_s;
    logic chg_en_low_s;
    logic chg_pol_s;

    upc_sync #(.RST_VAL(upc_pkg::SYNC_RST_LOW)) u_sync_ref (
        .clk(clk), .rst_n(rst_n), .d(reference_clock_in), .q(ref_s)
    );
    upc_sync #(.RST_VAL(upc_pkg::SYNC_RST_LOW)) u_sync_freq (
        .clk(clk), .rst_n(rst_n), .d(ref_freq_sel), .q(freq_s)
    );
    // Chip selects reset to the deselected levels
    upc_sync #(.RST_VAL(upc_pkg::SYNC_RST_LOW)) u_sync_cs (
        .clk(clk), .rst_n(rst_n), .d(chip_sel), .q(cs_s)
    );
    upc_sync #(.RST_VAL(upc_pkg::SYNC_RST_HIGH)) u_sync_csn (
        .clk(clk), .rst_n(rst_n), .d(chip_sel_low), .q(csn_s)
    );
    upc_sync #(.RST_VAL(upc_pkg::SYNC_RST_LOW)) u_sync_fault (
        .clk(clk), .rst_n(rst_n), .d(vbus_fault_in), .q(fault_s)
    );
    // Charger pins live on the always-on reset, untouched by chip reset
    upc_sync #(.RST_VAL(upc_pkg::SYNC_RST_HIGH)) u_sync_chg_en (
        .clk(clk), .rst_n(aon_rst_n), .d(charger_detect_enable_low),
        .q(chg_en_low_s)
    );
    upc_sync #(.RST_VAL(upc_pkg::SYNC_RST_LOW)) u_sync_chg_pol (
        .clk(clk), .rst_n(aon_rst_n), .d(charger_out_polarity),
        .q(chg_pol_s)
    );

    // ------------------------------------------------------------------
    // Reference clock detection
    // ------------------------------------------------------------------
    upc_pkg::upc_ref_state_e ref_state_ff;
    logic ref_prev_ff;
    logic ref_edge;
    logic gap_hit;
    logic [3:0] edge_cnt_ff;
    logic [4:0] gap_cnt_ff;

    assign ref_edge = ref_s && !ref_prev_ff;
    assign gap_hit = (gap_cnt_ff == upc_pkg::REF_GAP_MAX);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_prev_ff <= 1'b0;
        end else begin
            ref_prev_ff <= ref_s;
        end
    end

    // Cycles since the last rising edge, saturating at the limit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_cnt_ff <= 5'h00;
        end else if (ref_edge) begin
            gap_cnt_ff <= 5'h00;
        end else if (!gap_hit) begin
            gap_cnt_ff <= gap_cnt_ff + 5'h01;
        end
    end

    // A glitch or a stray edge never flips the clock pin direction
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_state_ff <= upc_pkg::UPC_REF_ABSENT;
            edge_cnt_ff <= 4'h0;
        end else begin
            unique case (ref_state_ff)
                upc_pkg::UPC_REF_ABSENT: begin
                    if (ref_edge) begin
                        ref_state_ff <= upc_pkg::UPC_REF_COUNTING;
                        edge_cnt_ff <= 4'h1;
                    end
                end
                upc_pkg::UPC_REF_COUNTING: begin
                    if (gap_hit) begin
                        ref_state_ff <= upc_pkg::UPC_REF_ABSENT;
                        edge_cnt_ff <= 4'h0;
                    end else if (ref_edge) begin
                        if (edge_cnt_ff == upc_pkg::REF_EDGES_NEEDED - 4'h1)
                        begin
                            ref_state_ff <= upc_pkg::UPC_REF_PRESENT;
                        end
                        edge_cnt_ff <= edge_cnt_ff + 4'h1;
                    end
                end
                upc_pkg::UPC_REF_PRESENT: begin
                    if (gap_hit) begin
                        ref_state_ff <= upc_pkg::UPC_REF_ABSENT;
                        edge_cnt_ff <= 4'h0;
                    end
                end
                default: begin
                    ref_state_ff <= upc_pkg::UPC_REF_ABSENT;
                    edge_cnt_ff <= 4'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Chip select, power and PLL
    // ------------------------------------------------------------------
    logic chip_active_ff;
    logic pll_enable_ff;
    logic pll_ref_26m_ff;

    // Either select deasserted means power down
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chip_active_ff <= 1'b0;
        end else begin
            chip_active_ff <= cs_s && !csn_s;
        end
    end

    // PLL stays off through reset and power down
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_enable_ff <= 1'b0;
        end else begin
            pll_enable_ff <= chip_active_ff;
        end
    end

    // Frequency pin trusted as set by the board
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_ref_26m_ff <= upc_pkg::REF_SEL_19M2;
        end else begin
            pll_ref_26m_ff <= (freq_s == upc_pkg::REF_SEL_26M);
        end
    end

    assign chip_active = chip_active_ff;
    assign ulpi_bus_tristate = !chip_active_ff;
    assign pll_enable = pll_enable_ff;
    assign pll_ref_26m = pll_ref_26m_ff;

    // ------------------------------------------------------------------
    // ULPI clock pin direction
    // ------------------------------------------------------------------
    // Stand-in for the PLL output: a toggle of the core clock
    logic clk_drive_ff;
    logic clk_oe_ff;
    logic ref_present;

    assign ref_present = (ref_state_ff == upc_pkg::UPC_REF_PRESENT);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_oe_ff <= 1'b0;
        end else begin
            clk_oe_ff <= ref_present && chip_active_ff;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_drive_ff <= 1'b0;
        // Select loss stops the clock at once, not one PLL cycle later
        end else if (ref_present && pll_enable_ff && chip_active_ff) begin
            clk_drive_ff <= !clk_drive_ff;
        end else begin
            clk_drive_ff <= 1'b0;
        end
    end

    assign ulpi_clk_o = clk_drive_ff;
    assign ulpi_clk_oe = clk_oe_ff;
    // Transfers are timed by the pin whenever the pin is an input
    assign ulpi_clk_from_pin = !clk_oe_ff;

    // ------------------------------------------------------------------
    // Start-of-frame output
    // ------------------------------------------------------------------
    logic sof_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sof_ff <= 1'b0;
        end else if (!sof_out_en) begin
            sof_ff <= 1'b0;
        end else if (hs_sof_rx) begin
            sof_ff <= !sof_ff;
        end
    end

    assign sof_out = sof_ff;

    // ------------------------------------------------------------------
    // Charger detection pins, always-on domain
    // ------------------------------------------------------------------
    logic chg_start_ff;
    logic chg_o_ff;
    logic chg_oe_ff;

    always_ff @(posedge clk or negedge aon_rst_n) begin
        if (!aon_rst_n) begin
            chg_start_ff <= 1'b0;
        end else begin
            chg_start_ff <= dead_battery_mode && !chg_en_low_s;
        end
    end

    // Open drain when active low, open source when active high
    always_ff @(posedge clk or negedge aon_rst_n) begin
        if (!aon_rst_n) begin
            chg_o_ff <= upc_pkg::POL_ACTIVE_LOW;
            chg_oe_ff <= 1'b0;
        end else begin
            chg_o_ff <= chg_pol_s;
            chg_oe_ff <= charger_found;
        end
    end

    assign charger_detect_start = chg_start_ff;
    assign charger_detected_o = chg_o_ff;
    assign charger_detected_oe = chg_oe_ff;

    // ------------------------------------------------------------------
    // Outside VBUS indicator
    // ------------------------------------------------------------------
    logic vbus_ind_ff;
    logic fault_pol;

    assign fault_pol = fault_s ^ vbus_flag_invert;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vbus_ind_ff <= 1'b0;
        end else if (!use_outside_vbus_flag) begin
            vbus_ind_ff <= 1'b0;
        end else if (vbus_flag_bypass) begin
            vbus_ind_ff <= fault_pol;
        end else begin
            vbus_ind_ff <= fault_pol && vbus_valid_cmp;
        end
    end

    assign outside_vbus_valid = vbus_ind_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_csn_high;
        chip_sel_low [*3];
    endsequence

    sequence s_cs_low;
        (!chip_sel) [*3];
    endsequence

    sequence s_fault_steady;
        (vbus_fault_in && use_outside_vbus_flag && vbus_flag_bypass &&
         !vbus_flag_invert) [*3];
    endsequence

    property p_clk_input;
        @(posedge clk) disable iff (!rst_n)
        !ref_present |=> !ulpi_clk_oe && ulpi_clk_from_pin;
    endproperty
    a_clk_input: assert property (p_clk_input)
        else $error("ULPI clock driven without reference clock");

    property p_clk_output;
        @(posedge clk) disable iff (!rst_n)
        ref_present && chip_active_ff |=> ulpi_clk_oe;
    endproperty
    a_clk_output: assert property (p_clk_output)
        else $error("ULPI clock not driven with reference present");

    property p_ref_edges;
        @(posedge clk) disable iff (!rst_n)
        $rose(ref_present) |-> $past(ref_edge) &&
            $past(edge_cnt_ff) == upc_pkg::REF_EDGES_NEEDED - 4'h1;
    endproperty
    a_ref_edges: assert property (p_ref_edges)
        else $error("Reference clock declared present too early");

    property p_charger_keeps;
        @(posedge clk) disable iff (!aon_rst_n)
        charger_found && !rst_n |=> charger_detected_oe;
    endproperty
    a_charger_keeps: assert property (p_charger_keeps)
        else $error("Charger output disturbed by chip reset");

    property p_pll_off;
        @(posedge clk) disable iff (!rst_n)
        !chip_active_ff |=> !pll_enable && !ulpi_clk_o;
    endproperty
    a_pll_off: assert property (p_pll_off)
        else $error("PLL running while powered down");

    property p_sof_low;
        @(posedge clk) disable iff (!rst_n)
        !sof_out_en |=> !sof_out;
    endproperty
    a_sof_low: assert property (p_sof_low)
        else $error("SOF output high while disabled");

    property p_sof_toggle;
        @(posedge clk) disable iff (!rst_n)
        sof_out_en && hs_sof_rx |=> sof_out != $past(sof_out);
    endproperty
    a_sof_toggle: assert property (p_sof_toggle)
        else $error("SOF output missed a packet");

    property p_csn_down;
        @(posedge clk) disable iff (!rst_n)
        s_csn_high |=> ulpi_bus_tristate && !chip_active;
    endproperty
    a_csn_down: assert property (p_csn_down)
        else $error("Bus not tri-stated with active-low select high");

    property p_cs_down;
        @(posedge clk) disable iff (!rst_n)
        s_cs_low |=> ulpi_bus_tristate ##1 !ulpi_clk_oe;
    endproperty
    a_cs_down: assert property (p_cs_down)
        else $error("Bus not tri-stated with select low");

    property p_chg_ignored;
        @(posedge clk) disable iff (!aon_rst_n)
        !dead_battery_mode |=> !charger_detect_start;
    endproperty
    a_chg_ignored: assert property (p_chg_ignored)
        else $error("Charger detection started in active mode");

    property p_vbus_ignored;
        @(posedge clk) disable iff (!rst_n)
        !use_outside_vbus_flag |=> !outside_vbus_valid;
    endproperty
    a_vbus_ignored: assert property (p_vbus_ignored)
        else $error("Fault input used without enable");

    property p_vbus_invert;
        @(posedge clk) disable iff (!rst_n)
        use_outside_vbus_flag && vbus_flag_bypass |=>
            outside_vbus_valid == ($past(fault_s) ^ $past(vbus_flag_invert));
    endproperty
    a_vbus_invert: assert property (p_vbus_invert)
        else $error("Fault polarity wrong");

    property p_vbus_qualify;
        @(posedge clk) disable iff (!rst_n)
        use_outside_vbus_flag && !vbus_flag_bypass && !vbus_valid_cmp
            |=> !outside_vbus_valid;
    endproperty
    a_vbus_qualify: assert property (p_vbus_qualify)
        else $error("Fault not qualified by VBUS valid");

    property p_chg_pol;
        @(posedge clk) disable iff (!aon_rst_n)
        charger_found |=> charger_detected_oe &&
            charger_detected_o == $past(chg_pol_s);
    endproperty
    a_chg_pol: assert property (p_chg_pol)
        else $error("Charger output polarity wrong");

    property p_fault_sync;
        @(posedge clk) disable iff (!rst_n)
        s_fault_steady |=> outside_vbus_valid;
    endproperty
    a_fault_sync: assert property (p_fault_sync)
        else $error("Fault input not through after three cycles");

endmodule : upc_pin_ctrl

`default_nettype wire

// ### core/upc_pkg.sv
`default_nettype none

package upc_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    // Least low time of the chip reset pin, kept by whoever drives it
    localparam int RESET_MIN_US = 100;
    localparam int RESET_MIN_CYC = CLK_MHZ * RESET_MIN_US;

    // ------------------------------------------------------------------
    // Reference clock detection
    // ------------------------------------------------------------------
    // Rising edges seen back to back before the clock counts as present
    localparam logic [3:0] REF_EDGES_NEEDED = 4'h4;
    // Cycles without an edge after which the clock counts as gone
    localparam logic [4:0] REF_GAP_MAX = 5'h10;

    // ------------------------------------------------------------------
    // Pin encodings and reset values
    // ------------------------------------------------------------------
    localparam logic REF_SEL_19M2 = 1'b0;
    localparam logic REF_SEL_26M = 1'b1;
    localparam logic POL_ACTIVE_LOW = 1'b0;
    localparam logic POL_ACTIVE_HIGH = 1'b1;
    localparam logic SYNC_RST_LOW = 1'b0;
    localparam logic SYNC_RST_HIGH = 1'b1;

    typedef enum logic [1:0] {
        UPC_REF_ABSENT = 2'b00,
        UPC_REF_COUNTING = 2'b01,
        UPC_REF_PRESENT = 2'b11
    } upc_ref_state_e;

endpackage : upc_pkg

`default_nettype wire

// ### core/upc_sync.sv
`timescale 1ns/10ps
`default_nettype none

module upc_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);

    // ------------------------------------------------------------------
    // Two-stage synchroniser
    // ------------------------------------------------------------------
    // The first stage feeds only the second; nothing else may read it
    logic meta_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end

endmodule : upc_sync

`default_nettype wire

// ### test/upc_link_model.sv
`timescale 1ns/10ps
`default_nettype none

module upc_link_model (
    input wire logic clk,
    input wire logic ulpi_clk_o,
    input wire logic ulpi_clk_oe,
    output logic ulpi_clk_pin
);

    // ------------------------------------------------------------------
    // Link side of the ULPI clock pin
    // ------------------------------------------------------------------
    // Free-running stand-in for the link's own 60 MHz source
    logic link_clk_ff;

    initial link_clk_ff = 1'b0;

    always @(posedge clk) begin
        link_clk_ff <= ~link_clk_ff;
    end

    // Link drives the pin only while the transceiver leaves it an input;
    // the resolved level feeds only the transceiver's ulpi_clk_i
    assign ulpi_clk_pin = ulpi_clk_oe ? ulpi_clk_o : link_clk_ff;

endmodule : upc_link_model

`default_nettype wire

// ### test/upc_pin_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none

module upc_pin_ctrl_tb;

    // ------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic aon_rst_n = 1'b0;
    logic reference_clock_in = 1'b0;
    logic ref_run = 1'b0;
    logic ref_freq_sel = upc_pkg::REF_SEL_19M2;
    logic chip_sel = 1'b0;
    logic chip_sel_low = 1'b1;
    logic sof_out_en = 1'b0;
    logic hs_sof_rx = 1'b0;
    logic dead_battery_mode = 1'b0;
    logic charger_detect_enable_low = 1'b1;
    logic charger_found = 1'b0;
    logic charger_out_polarity = 1'b0;
    logic vbus_fault_in = 1'b0;
    logic use_outside_vbus_flag = 1'b0;
    logic vbus_flag_invert = 1'b0;
    logic vbus_flag_bypass = 1'b0;
    logic vbus_valid_cmp = 1'b0;
    logic ulpi_clk_pin, ulpi_clk_o, ulpi_clk_oe, ulpi_clk_from_pin;
    logic pll_enable, pll_ref_26m, chip_active, ulpi_bus_tristate;
    logic sof_out, charger_detect_start, charger_detected_o;
    logic charger_detected_oe, outside_vbus_valid;
    logic sof_exp, exp, f, last;
    int miscompares = 0;
    int checks_done = 0;

    always #20 clk = ~clk;

    // Reference clock runs only while enabled, phase offset from clk
    initial begin
        #7;
        forever #160 reference_clock_in = ref_run ? ~reference_clock_in : 1'b0;
    end

    upc_pin_ctrl dut (
        .clk(clk), .rst_n(rst_n), .aon_rst_n(aon_rst_n),
        .reference_clock_in(reference_clock_in),
        .ref_freq_sel(ref_freq_sel), .chip_sel(chip_sel),
        .chip_sel_low(chip_sel_low), .ulpi_clk_i(ulpi_clk_pin),
        .ulpi_clk_o(ulpi_clk_o), .ulpi_clk_oe(ulpi_clk_oe),
        .ulpi_clk_from_pin(ulpi_clk_from_pin), .pll_enable(pll_enable),
        .pll_ref_26m(pll_ref_26m), .chip_active(chip_active),
        .ulpi_bus_tristate(ulpi_bus_tristate), .sof_out_en(sof_out_en),
        .hs_sof_rx(hs_sof_rx), .sof_out(sof_out),
        .dead_battery_mode(dead_battery_mode),
        .charger_detect_enable_low(charger_detect_enable_low),
        .charger_detect_start(charger_detect_start),
        .charger_found(charger_found),
        .charger_out_polarity(charger_out_polarity),
        .charger_detected_o(charger_detected_o),
        .charger_detected_oe(charger_detected_oe),
        .vbus_fault_in(vbus_fault_in),
        .use_outside_vbus_flag(use_outside_vbus_flag),
        .vbus_flag_invert(vbus_flag_invert),
        .vbus_flag_bypass(vbus_flag_bypass),
        .vbus_valid_cmp(vbus_valid_cmp),
        .outside_vbus_valid(outside_vbus_valid)
    );

    upc_link_model link (
        .clk(clk), .ulpi_clk_o(ulpi_clk_o), .ulpi_clk_oe(ulpi_clk_oe),
        .ulpi_clk_pin(ulpi_clk_pin)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic seen, input logic e);
        checks_done++;
        if (seen !== e) begin
            miscompares++;
            $display("Error %s expected %b seen %b", name, e, seen);
        end
    endtask : check

    // Lands 1 ns after the edge so its updates have settled
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wait_oe(input logic val);
        int n;
        n = 0;
        while (ulpi_clk_oe !== val && n < 200) begin
            tick(1);
            n++;
        end
        if (ulpi_clk_oe !== val) begin
            check("ulpi_clk_oe", ulpi_clk_oe, val);
            give_verdict();
        end
    endtask : wait_oe

    task automatic sof_pulse(input int n);
        @(posedge clk) hs_sof_rx <= 1'b1;
        repeat (n) @(posedge clk);
        hs_sof_rx <= 1'b0;
        #1;
        sof_exp = sof_exp ^ n[0];
        check("sof_out", sof_out, sof_exp);
    endtask : sof_pulse

    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        tick(5);
        check("ulpi_clk_oe", ulpi_clk_oe, 1'b0);
        check("ulpi_clk_from_pin", ulpi_clk_from_pin, 1'b1);
        check("pll_enable", pll_enable, 1'b0);
        check("ulpi_bus_tristate", ulpi_bus_tristate, 1'b1);
        check("sof_out", sof_out, 1'b0);
        @(posedge clk);
        rst_n <= 1'b1;
        aon_rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            chip_sel <= i[1];
            chip_sel_low <= i[0];
            tick(6);
            exp = i[1] & ~i[0];
            check("chip_active", chip_active, exp);
            check("ulpi_bus_tristate", ulpi_bus_tristate, ~exp);
            check("pll_enable", pll_enable, exp);
        end
        @(posedge clk) chip_sel_low <= 1'b0;
        tick(2);
        check("chip_active", chip_active, 1'b0);
        tick(1);
        check("chip_active", chip_active, 1'b1);
        check("pll_enable", pll_enable, 1'b0);
        tick(1);
        check("pll_enable", pll_enable, 1'b1);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk) ref_freq_sel <= ~i[0];
            tick(2);
            check("pll_ref_26m", pll_ref_26m, i[0]);
            tick(1);
            check("pll_ref_26m", pll_ref_26m, ~i[0]);
        end
        // Too few reference edges must not flip the clock direction
        @(posedge clk) ref_run <= 1'b1;
        tick(12);
        check("ulpi_clk_oe", ulpi_clk_oe, 1'b0);
        wait_oe(1'b1);
        check("ulpi_clk_from_pin", ulpi_clk_from_pin, 1'b0);
        tick(1);
        last = ulpi_clk_o;
        tick(1);
        check("ulpi_clk_o", ulpi_clk_o, ~last);
        // Chip reset mid-run must spare the charger pins
        @(posedge clk);
        charger_found <= 1'b1;
        charger_out_polarity <= upc_pkg::POL_ACTIVE_HIGH;
        tick(5);
        check("charger_detected_oe", charger_detected_oe, 1'b1);
        check("charger_detected_o", charger_detected_o, 1'b1);
        @(posedge clk) rst_n <= 1'b0;
        tick(2);
        check("ulpi_clk_oe", ulpi_clk_oe, 1'b0);
        check("pll_enable", pll_enable, 1'b0);
        check("ulpi_bus_tristate", ulpi_bus_tristate, 1'b1);
        check("charger_detected_oe", charger_detected_oe, 1'b1);
        // Reset pulse kept to the least width the pin asks for
        tick(upc_pkg::RESET_MIN_CYC);
        @(posedge clk) rst_n <= 1'b1;
        wait_oe(1'b1);
        check("ulpi_clk_from_pin", ulpi_clk_from_pin, 1'b0);
        @(posedge clk) ref_run <= 1'b0;
        wait_oe(1'b0);
        check("ulpi_clk_from_pin", ulpi_clk_from_pin, 1'b1);
        @(posedge clk) charger_out_polarity <= upc_pkg::POL_ACTIVE_LOW;
        tick(5);
        check("charger_detected_o", charger_detected_o, 1'b0);
        @(posedge clk) charger_found <= 1'b0;
        tick(3);
        check("charger_detected_oe", charger_detected_oe, 1'b0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            dead_battery_mode <= i[1];
            charger_detect_enable_low <= i[0];
            tick(5);
            exp = i[1] & ~i[0];
            check("charger_detect_start", charger_detect_start, exp);
        end
        // Every combination of the link's indicator bits
        for (int i = 0; i < 32; i++) begin
            @(posedge clk);
            use_outside_vbus_flag <= i[4];
            vbus_flag_invert <= i[3];
            vbus_flag_bypass <= i[2];
            vbus_valid_cmp <= i[1];
            vbus_fault_in <= i[0];
            tick(5);
            f = i[0] ^ i[3];
            exp = i[4] & (i[2] ? f : (f & i[1]));
            check("outside_vbus_valid", outside_vbus_valid, exp);
        end
        @(posedge clk) hs_sof_rx <= 1'b1;
        @(posedge clk) hs_sof_rx <= 1'b0;
        tick(1);
        check("sof_out", sof_out, 1'b0);
        @(posedge clk) sof_out_en <= 1'b1;
        sof_exp = 1'b0;
        repeat (3) sof_pulse(1);
        sof_pulse(2);
        @(posedge clk) sof_out_en <= 1'b0;
        tick(1);
        check("sof_out", sof_out, 1'b0);
        give_verdict();
    end

endmodule : upc_pin_ctrl_tb

`default_nettype wire
